/* File: rtl/spm_pkg.sv */
`default_nettype none
package spm_pkg;
	// ********************************
	// register map
	// ********************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_FLAGS = 4'h2;
	localparam logic [3:0] ADDR_COMM_DATA = 4'h3;
	localparam logic [3:0] ADDR_PRN_DATA = 4'h4;
	localparam logic [3:0] ADDR_COMM_DIV_LO = 4'h5;
	localparam logic [3:0] ADDR_COMM_DIV_HI = 4'h6;
	localparam logic [3:0] ADDR_PRN_DIV_LO = 4'h7;
	localparam logic [3:0] ADDR_PRN_DIV_HI = 4'h8;
	localparam logic [3:0] ADDR_SEC = 4'h9;
	// control bit positions
	localparam int CTL_SYNC = 0;
	localparam int CTL_SEND_REQ = 1;
	localparam int CTL_TERM_READY = 2;
	localparam int CTL_SEC_REQ = 3;
	localparam int CTL_SPEED = 4;
	localparam int CTL_PROTO = 5;
	localparam int CTL_PRN_IGNORE = 7;
	// flag bit positions
	localparam int FL_COMM_PEND = 0;
	localparam int FL_COMM_BUSY = 1;
	localparam int FL_COMM_FULL = 2;
	localparam int FL_COMM_OVR = 3;
	localparam int FL_PRN_PEND = 4;
	localparam int FL_PRN_BUSY = 5;
	localparam int FL_PRN_FULL = 6;
	localparam int FL_RING = 7;
	// synchroniser lane positions
	localparam int IN_CTS = 0;
	localparam int IN_DSR = 1;
	localparam int IN_CD = 2;
	localparam int IN_RI = 3;
	localparam int IN_SI = 4;
	localparam int IN_SCTS = 5;
	localparam int IN_CRXD = 6;
	localparam int IN_SCLK = 7;
	localparam int IN_RCLK = 8;
	localparam int IN_PRDY = 9;
	localparam int IN_PRXD = 10;
	localparam int IN_W = 11;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [10:0] SYNC_RST = 11'h7FF;
	localparam logic [15:0] DIV_RST = 16'h0103;
	// oversampling: 16 ticks a bit, mid sample at 7
	localparam logic [3:0] PHASE_MID = 4'h7;
	localparam logic [3:0] PHASE_LAST = 4'hF;
	localparam logic [2:0] BIT_LAST = 3'h7;
	typedef enum logic [1:0] {
		PROTO_DATA_ONLY = 2'h0,
		PROTO_MODEM = 2'h1,
		PROTO_ASYM = 2'h2
	} spm_proto_t;
	typedef enum logic [3:0] {
		FR_IDLE = 4'h1,
		FR_START = 4'h2,
		FR_DATA = 4'h4,
		FR_STOP = 4'h8
	} spm_frame_t;
endpackage : spm_pkg
`default_nettype wire

/* File: rtl/spm_serial_lane.sv */
`default_nettype none
module spm_serial_lane (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [15:0] div_in,
	input wire logic sync_in,
	input wire logic tx_edge_in,
	input wire logic rx_edge_in,
	input wire logic start_in,
	input wire logic [7:0] data_in,
	input wire logic rxd_in,
	output logic accept_out,
	output logic busy_out,
	output logic txd_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out
);
	// ********************************
	// state
	// ********************************
	logic [15:0] div_ff, nxt_div_ff;
	spm_pkg::spm_frame_t tx_state_ff, nxt_tx_state_ff, rx_state_ff, nxt_rx_state_ff;
	logic [3:0] tx_phase_ff, nxt_tx_phase_ff, rx_phase_ff, nxt_rx_phase_ff;
	logic [2:0] tx_bit_ff, nxt_tx_bit_ff, rx_bit_ff, nxt_rx_bit_ff;
	logic [7:0] tx_shift_ff, nxt_tx_shift_ff, rx_shift_ff, nxt_rx_shift_ff;
	logic txd_ff, nxt_txd_ff, rx_valid_ff, nxt_rx_valid_ff;
	logic [7:0] rx_data_ff, nxt_rx_data_ff;
	logic tick, tx_step, rx_step, rx_mid;

	// 16x tick; unused while clocked by the modem
	assign tick = (div_ff == 16'h0000);
	assign tx_step = sync_in ? tx_edge_in : (tick && tx_phase_ff == spm_pkg::PHASE_LAST);
	assign rx_step = sync_in ? rx_edge_in : (tick && rx_phase_ff == spm_pkg::PHASE_LAST);
	assign rx_mid = !sync_in && tick && rx_phase_ff == spm_pkg::PHASE_MID;
	// in modem clock mode a frame only starts on a send clock edge
	assign accept_out = start_in && tx_state_ff == spm_pkg::FR_IDLE && (!sync_in || tx_edge_in);
	assign busy_out = tx_state_ff != spm_pkg::FR_IDLE;
	assign txd_out = txd_ff;
	assign rx_data_out = rx_data_ff;
	assign rx_valid_out = rx_valid_ff;

	// ********************************
	// transmitter, 8 data bits, 1 stop
	// ********************************
	always_comb begin
		nxt_div_ff = tick ? div_in : 16'(div_ff - 16'h0001);
		nxt_tx_state_ff = tx_state_ff;
		nxt_tx_phase_ff = (tick && !sync_in) ? 4'(tx_phase_ff + 4'h1) : tx_phase_ff;
		nxt_tx_bit_ff = tx_bit_ff;
		nxt_tx_shift_ff = tx_shift_ff;
		nxt_txd_ff = txd_ff;
		unique case (tx_state_ff)
			spm_pkg::FR_IDLE: begin
				nxt_txd_ff = 1'b1; // mark between characters
				if (accept_out) begin
					nxt_tx_state_ff = spm_pkg::FR_START;
					nxt_tx_shift_ff = data_in;
					nxt_tx_phase_ff = 4'h0;
					nxt_txd_ff = 1'b0;
				end
			end
			spm_pkg::FR_START: if (tx_step) begin
				nxt_tx_state_ff = spm_pkg::FR_DATA;
				nxt_txd_ff = tx_shift_ff[0];
				nxt_tx_bit_ff = 3'h0;
			end
			spm_pkg::FR_DATA: if (tx_step) begin
				if (tx_bit_ff == spm_pkg::BIT_LAST) begin
					nxt_tx_state_ff = spm_pkg::FR_STOP;
					nxt_txd_ff = 1'b1;
				end else begin
					nxt_tx_bit_ff = 3'(tx_bit_ff + 3'h1);
					nxt_tx_shift_ff = tx_shift_ff >> 1;
					nxt_txd_ff = tx_shift_ff[1];
				end
			end
			spm_pkg::FR_STOP: if (tx_step) nxt_tx_state_ff = spm_pkg::FR_IDLE;
			default: nxt_tx_state_ff = spm_pkg::FR_IDLE;
		endcase
	end

	// ********************************
	// receiver
	// ********************************
	// framing errors drop the character silently
	always_comb begin
		nxt_rx_state_ff = rx_state_ff;
		nxt_rx_phase_ff = (tick && !sync_in) ? 4'(rx_phase_ff + 4'h1) : rx_phase_ff;
		nxt_rx_bit_ff = rx_bit_ff;
		nxt_rx_shift_ff = rx_shift_ff;
		nxt_rx_data_ff = rx_data_ff;
		nxt_rx_valid_ff = 1'b0;
		unique case (rx_state_ff)
			spm_pkg::FR_IDLE: begin
				nxt_rx_phase_ff = 4'h0;
				nxt_rx_bit_ff = 3'h0;
				if (!rxd_in && (!sync_in || rx_edge_in))
					nxt_rx_state_ff = sync_in ? spm_pkg::FR_DATA : spm_pkg::FR_START;
			end
			spm_pkg::FR_START: if (rx_mid) begin
				nxt_rx_phase_ff = 4'h0;
				nxt_rx_state_ff = rxd_in ? spm_pkg::FR_IDLE : spm_pkg::FR_DATA;
			end
			spm_pkg::FR_DATA: if (rx_step) begin
				nxt_rx_shift_ff = {rxd_in, rx_shift_ff[7:1]};
				nxt_rx_bit_ff = 3'(rx_bit_ff + 3'h1);
				if (rx_bit_ff == spm_pkg::BIT_LAST) nxt_rx_state_ff = spm_pkg::FR_STOP;
			end
			spm_pkg::FR_STOP: if (rx_step) begin
				nxt_rx_state_ff = spm_pkg::FR_IDLE;
				nxt_rx_valid_ff = rxd_in;
				if (rxd_in) nxt_rx_data_ff = rx_shift_ff;
			end
			default: nxt_rx_state_ff = spm_pkg::FR_IDLE;
		endcase
	end

	// registers of both directions
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_ff <= spm_pkg::DIV_RST;
			tx_state_ff <= spm_pkg::FR_IDLE;
			rx_state_ff <= spm_pkg::FR_IDLE;
			tx_phase_ff <= 4'h0;
			rx_phase_ff <= 4'h0;
			tx_bit_ff <= 3'h0;
			rx_bit_ff <= 3'h0;
			tx_shift_ff <= 8'h00;
			rx_shift_ff <= 8'h00;
			txd_ff <= 1'b1;
			rx_data_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div_ff;
			tx_state_ff <= nxt_tx_state_ff;
			rx_state_ff <= nxt_rx_state_ff;
			tx_phase_ff <= nxt_tx_phase_ff;
			rx_phase_ff <= nxt_rx_phase_ff;
			tx_bit_ff <= nxt_tx_bit_ff;
			rx_bit_ff <= nxt_rx_bit_ff;
			tx_shift_ff <= nxt_tx_shift_ff;
			rx_shift_ff <= nxt_rx_shift_ff;
			txd_ff <= nxt_txd_ff;
			rx_data_ff <= nxt_rx_data_ff;
			rx_valid_ff <= nxt_rx_valid_ff;
		end
	end
endmodule : spm_serial_lane
`default_nettype wire

/* File: rtl/spm_line_ctrl.sv */
// The register offsets and strobed register access were decided locally.
`default_nettype none
module spm_line_ctrl (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic comm_transmit_data_out,
	input wire logic comm_receive_data_in,
	output logic send_request_out,
	input wire logic clear_to_send_in,
	input wire logic data_set_ready_in,
	input wire logic carrier_detect_in,
	input wire logic speed_indicator_secondary_detect_in,
	input wire logic sec_clear_to_send_in,
	output logic sec_transmit_data_out,
	input wire logic send_clock_in,
	input wire logic modem_receive_clock_in,
	output logic secondary_send_request_out,
	output logic terminal_ready_out,
	input wire logic ring_indicator_in,
	output logic modem_speed_select_out,
	output logic printer_data_out,
	input wire logic printer_data_in,
	output logic printer_cts_out,
	output logic printer_dsr_out,
	input wire logic printer_ready_in
);
	// ********************************
	// input synchronisers
	// ********************************
	logic [spm_pkg::IN_W-1:0] sync1_ff, sync2_ff, nxt_sync1_ff;
	logic sclk_prev_ff, rclk_prev_ff;
	logic comm_tx_edge, comm_rx_edge;
	logic cts_on, dsr_on, cd_on, ri_on, si_on, scts_on, prn_ready_on;

	// gather every pin from outside the clock's domain
	always_comb begin
		nxt_sync1_ff = spm_pkg::SYNC_RST;
		nxt_sync1_ff[spm_pkg::IN_CTS] = clear_to_send_in;
		nxt_sync1_ff[spm_pkg::IN_DSR] = data_set_ready_in;
		nxt_sync1_ff[spm_pkg::IN_CD] = carrier_detect_in;
		nxt_sync1_ff[spm_pkg::IN_RI] = ring_indicator_in;
		nxt_sync1_ff[spm_pkg::IN_SI] = speed_indicator_secondary_detect_in;
		nxt_sync1_ff[spm_pkg::IN_SCTS] = sec_clear_to_send_in;
		nxt_sync1_ff[spm_pkg::IN_CRXD] = comm_receive_data_in;
		nxt_sync1_ff[spm_pkg::IN_SCLK] = send_clock_in;
		nxt_sync1_ff[spm_pkg::IN_RCLK] = modem_receive_clock_in;
		nxt_sync1_ff[spm_pkg::IN_PRDY] = printer_ready_in;
		nxt_sync1_ff[spm_pkg::IN_PRXD] = printer_data_in;
	end

	// two stages, then one more for clock edge finding
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1_ff <= spm_pkg::SYNC_RST;
			sync2_ff <= spm_pkg::SYNC_RST;
			sclk_prev_ff <= 1'b1;
			rclk_prev_ff <= 1'b1;
		end else begin
			sync1_ff <= nxt_sync1_ff;
			sync2_ff <= sync1_ff;
			sclk_prev_ff <= sync2_ff[spm_pkg::IN_SCLK];
			rclk_prev_ff <= sync2_ff[spm_pkg::IN_RCLK];
		end
	end

	// data leaves on the falling send clock, is sampled on the rising receive clock
	assign comm_tx_edge = sclk_prev_ff && !sync2_ff[spm_pkg::IN_SCLK];
	assign comm_rx_edge = !rclk_prev_ff && sync2_ff[spm_pkg::IN_RCLK];
	// low level means on
	assign cts_on = !sync2_ff[spm_pkg::IN_CTS];
	assign dsr_on = !sync2_ff[spm_pkg::IN_DSR];
	assign cd_on = !sync2_ff[spm_pkg::IN_CD];
	assign ri_on = !sync2_ff[spm_pkg::IN_RI];
	assign si_on = !sync2_ff[spm_pkg::IN_SI];
	assign scts_on = !sync2_ff[spm_pkg::IN_SCTS];
	// printer ready is asserted high like the port's own outputs
	assign prn_ready_on = sync2_ff[spm_pkg::IN_PRDY];

	// ********************************
	// register file
	// ********************************
	logic [7:0] ctrl_ff, nxt_ctrl_ff;
	logic [15:0] comm_div_ff, nxt_comm_div_ff, prn_div_ff, nxt_prn_div_ff;
	logic [7:0] comm_hold_ff, nxt_comm_hold_ff, prn_hold_ff, nxt_prn_hold_ff;
	logic [7:0] comm_rxbuf_ff, nxt_comm_rxbuf_ff, prn_rxbuf_ff, nxt_prn_rxbuf_ff;
	logic comm_pend_ff, nxt_comm_pend_ff, prn_pend_ff, nxt_prn_pend_ff;
	logic comm_full_ff, nxt_comm_full_ff, prn_full_ff, nxt_prn_full_ff;
	logic comm_ovr_ff, nxt_comm_ovr_ff, ring_ff, nxt_ring_ff, ri_prev_ff;
	logic sec_bit_ff, nxt_sec_bit_ff;
	logic [7:0] rdata_ff, nxt_rdata_ff;
	spm_pkg::spm_proto_t proto;
	logic sync_mode, comm_allowed, prn_allowed;
	logic comm_accept, comm_busy, comm_txd, comm_rx_valid;
	logic prn_accept, prn_busy, prn_txd, prn_rx_valid;
	logic [7:0] comm_rx_data, prn_rx_data;

	// unused code 3 behaves as data leads only
	assign proto = spm_pkg::spm_proto_t'(ctrl_ff[spm_pkg::CTL_PROTO +: 2]);
	assign sync_mode = ctrl_ff[spm_pkg::CTL_SYNC];
	// modem protocols hold the character until the modem is clear
	assign comm_allowed = (proto != spm_pkg::PROTO_MODEM && proto != spm_pkg::PROTO_ASYM) || cts_on;
	// printer ready pauses output unless the earlier variant is selected
	assign prn_allowed = ctrl_ff[spm_pkg::CTL_PRN_IGNORE] || prn_ready_on;

	// status byte packing, used only by the status read
	function automatic logic [7:0] spm_status(input logic c, d, cd, r, s, sc, p);
		spm_status = {1'b0, p, sc, s, r, cd, d, c};
	endfunction : spm_status

	// writes, reads and hardware events; hardware sets win over clears
	always_comb begin
		nxt_ctrl_ff = ctrl_ff;
		nxt_comm_div_ff = comm_div_ff;
		nxt_prn_div_ff = prn_div_ff;
		nxt_comm_hold_ff = comm_hold_ff;
		nxt_prn_hold_ff = prn_hold_ff;
		nxt_comm_rxbuf_ff = comm_rxbuf_ff;
		nxt_prn_rxbuf_ff = prn_rxbuf_ff;
		nxt_comm_full_ff = comm_full_ff;
		nxt_prn_full_ff = prn_full_ff;
		nxt_comm_ovr_ff = comm_ovr_ff;
		nxt_ring_ff = ring_ff;
		nxt_sec_bit_ff = sec_bit_ff;
		nxt_rdata_ff = 8'h00;
		// accept before write so a byte written now is not lost
		nxt_comm_pend_ff = comm_pend_ff && !comm_accept;
		nxt_prn_pend_ff = prn_pend_ff && !prn_accept;
		if (wr_in) begin
			unique case (addr_in)
				spm_pkg::ADDR_CTRL: nxt_ctrl_ff = wdata_in;
				spm_pkg::ADDR_FLAGS: begin
					if (wdata_in[spm_pkg::FL_COMM_OVR]) nxt_comm_ovr_ff = 1'b0;
					if (wdata_in[spm_pkg::FL_RING]) nxt_ring_ff = 1'b0;
				end
				spm_pkg::ADDR_COMM_DATA: begin
					nxt_comm_hold_ff = wdata_in;
					nxt_comm_pend_ff = 1'b1;
				end
				spm_pkg::ADDR_PRN_DATA: begin
					nxt_prn_hold_ff = wdata_in;
					nxt_prn_pend_ff = 1'b1;
				end
				spm_pkg::ADDR_COMM_DIV_LO: nxt_comm_div_ff[7:0] = wdata_in;
				spm_pkg::ADDR_COMM_DIV_HI: nxt_comm_div_ff[15:8] = wdata_in;
				spm_pkg::ADDR_PRN_DIV_LO: nxt_prn_div_ff[7:0] = wdata_in;
				spm_pkg::ADDR_PRN_DIV_HI: nxt_prn_div_ff[15:8] = wdata_in;
				spm_pkg::ADDR_SEC: nxt_sec_bit_ff = wdata_in[0];
				default: ;
			endcase
		end
		if (rd_in) begin
			unique case (addr_in)
				spm_pkg::ADDR_CTRL: nxt_rdata_ff = ctrl_ff;
				// outside asymmetric mode secondary clear reads as primary
				spm_pkg::ADDR_STATUS: nxt_rdata_ff = spm_status(cts_on, dsr_on, cd_on, ri_on, si_on,
					(proto == spm_pkg::PROTO_ASYM) ? scts_on : cts_on, prn_ready_on);
				spm_pkg::ADDR_FLAGS: nxt_rdata_ff = {ring_ff, prn_full_ff, prn_busy, prn_pend_ff,
					comm_ovr_ff, comm_full_ff, comm_busy, comm_pend_ff};
				spm_pkg::ADDR_COMM_DATA: begin
					nxt_rdata_ff = comm_rxbuf_ff;
					nxt_comm_full_ff = 1'b0;
				end
				spm_pkg::ADDR_PRN_DATA: begin
					nxt_rdata_ff = prn_rxbuf_ff;
					nxt_prn_full_ff = 1'b0;
				end
				spm_pkg::ADDR_COMM_DIV_LO: nxt_rdata_ff = comm_div_ff[7:0];
				spm_pkg::ADDR_COMM_DIV_HI: nxt_rdata_ff = comm_div_ff[15:8];
				spm_pkg::ADDR_PRN_DIV_LO: nxt_rdata_ff = prn_div_ff[7:0];
				spm_pkg::ADDR_PRN_DIV_HI: nxt_rdata_ff = prn_div_ff[15:8];
				spm_pkg::ADDR_SEC: nxt_rdata_ff = {7'h00, sec_bit_ff};
				default: nxt_rdata_ff = 8'h00;
			endcase
		end
		if (comm_rx_valid) begin
			nxt_comm_ovr_ff = comm_ovr_ff || comm_full_ff;
			nxt_comm_full_ff = 1'b1;
			nxt_comm_rxbuf_ff = comm_rx_data;
		end
		// printer characters, flow control ones included, are buffered for software
		if (prn_rx_valid) begin
			nxt_prn_full_ff = 1'b1;
			nxt_prn_rxbuf_ff = prn_rx_data;
		end
		// ring start latched as incoming call
		if (ri_on && !ri_prev_ff) nxt_ring_ff = 1'b1;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_ff <= spm_pkg::CTRL_RST;
			comm_div_ff <= spm_pkg::DIV_RST;
			prn_div_ff <= spm_pkg::DIV_RST;
			comm_hold_ff <= 8'h00;
			prn_hold_ff <= 8'h00;
			comm_rxbuf_ff <= 8'h00;
			prn_rxbuf_ff <= 8'h00;
			comm_pend_ff <= 1'b0;
			prn_pend_ff <= 1'b0;
			comm_full_ff <= 1'b0;
			prn_full_ff <= 1'b0;
			comm_ovr_ff <= 1'b0;
			ring_ff <= 1'b0;
			ri_prev_ff <= 1'b0;
			sec_bit_ff <= 1'b1;
			rdata_ff <= 8'h00;
		end else begin
			ctrl_ff <= nxt_ctrl_ff;
			comm_div_ff <= nxt_comm_div_ff;
			prn_div_ff <= nxt_prn_div_ff;
			comm_hold_ff <= nxt_comm_hold_ff;
			prn_hold_ff <= nxt_prn_hold_ff;
			comm_rxbuf_ff <= nxt_comm_rxbuf_ff;
			prn_rxbuf_ff <= nxt_prn_rxbuf_ff;
			comm_pend_ff <= nxt_comm_pend_ff;
			prn_pend_ff <= nxt_prn_pend_ff;
			comm_full_ff <= nxt_comm_full_ff;
			prn_full_ff <= nxt_prn_full_ff;
			comm_ovr_ff <= nxt_comm_ovr_ff;
			ring_ff <= nxt_ring_ff;
			ri_prev_ff <= ri_on;
			sec_bit_ff <= nxt_sec_bit_ff;
			rdata_ff <= nxt_rdata_ff;
		end
	end

	// ********************************
	// serial lanes
	// ********************************
	// comm port switches to modem clocks in sync mode
	spm_serial_lane u_comm (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.div_in(comm_div_ff),
		.sync_in(sync_mode),
		.tx_edge_in(comm_tx_edge),
		.rx_edge_in(comm_rx_edge),
		.start_in(comm_pend_ff && comm_allowed),
		.data_in(comm_hold_ff),
		.rxd_in(sync2_ff[spm_pkg::IN_CRXD]),
		.accept_out(comm_accept),
		.busy_out(comm_busy),
		.txd_out(comm_txd),
		.rx_data_out(comm_rx_data),
		.rx_valid_out(comm_rx_valid)
	);

	// printer always runs on the internal rate
	spm_serial_lane u_prn (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.div_in(prn_div_ff),
		.sync_in(1'b0),
		.tx_edge_in(1'b0),
		.rx_edge_in(1'b0),
		.start_in(prn_pend_ff && prn_allowed),
		.data_in(prn_hold_ff),
		.rxd_in(sync2_ff[spm_pkg::IN_PRXD]),
		.accept_out(prn_accept),
		.busy_out(prn_busy),
		.txd_out(prn_txd),
		.rx_data_out(prn_rx_data),
		.rx_valid_out(prn_rx_valid)
	);

	// ********************************
	// pin outputs
	// ********************************
	logic [8:0] pins_ff, nxt_pins_ff;

	// a control bit of 1 turns the line on, which is logic 0
	always_comb begin
		nxt_pins_ff[0] = comm_txd;
		nxt_pins_ff[1] = !ctrl_ff[spm_pkg::CTL_SEND_REQ];
		nxt_pins_ff[2] = !ctrl_ff[spm_pkg::CTL_TERM_READY];
		nxt_pins_ff[3] = !ctrl_ff[spm_pkg::CTL_SEC_REQ];
		nxt_pins_ff[4] = !ctrl_ff[spm_pkg::CTL_SPEED];
		// secondary data copies primary unless asymmetric; marks while not clear
		if (proto == spm_pkg::PROTO_ASYM)
			nxt_pins_ff[5] = scts_on ? sec_bit_ff : 1'b1;
		else
			nxt_pins_ff[5] = comm_txd;
		nxt_pins_ff[6] = prn_txd;
		nxt_pins_ff[7] = 1'b1;
		nxt_pins_ff[8] = 1'b1;
	end

	// all lines off and marking out of reset
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) pins_ff <= 9'h1FF;
		else pins_ff <= nxt_pins_ff;
	end

	assign comm_transmit_data_out = pins_ff[0];
	assign send_request_out = pins_ff[1];
	assign terminal_ready_out = pins_ff[2];
	assign secondary_send_request_out = pins_ff[3];
	assign modem_speed_select_out = pins_ff[4];
	assign sec_transmit_data_out = pins_ff[5];
	assign printer_data_out = pins_ff[6];
	assign printer_cts_out = pins_ff[7];
	assign printer_dsr_out = pins_ff[8];
	assign rdata_out = rdata_ff;

	// ********************************
	// checks
	// ********************************
	a_comm_idle_mark: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$past(!comm_busy, 1) && $past(!comm_busy, 2) |-> comm_transmit_data_out)
		else $error("comm line not marking while idle");
	a_send_req_on: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wr_in && addr_in == spm_pkg::ADDR_CTRL && wdata_in[1] |=> ##1 !send_request_out)
		else $error("send request not on after control write");
	a_term_ready_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wr_in && addr_in == spm_pkg::ADDR_CTRL && !wdata_in[2] |=> ##1 terminal_ready_out)
		else $error("terminal ready not off after control write");
	a_sync_tx_clock: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$past(sync_mode) && $past(sync_mode, 2) && $changed(comm_txd) |-> $past(comm_tx_edge))
		else $error("sync transmit moved without send clock edge");
	a_prn_pause: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(prn_busy) |-> $past(ctrl_ff[spm_pkg::CTL_PRN_IGNORE]) || $past(prn_ready_on))
		else $error("printer character started while not ready");
	a_prn_fixed_high: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		printer_cts_out && printer_dsr_out)
		else $error("printer handshake outputs not high");
	a_prn_idle_mark: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$past(!prn_busy, 1) && $past(!prn_busy, 2) |-> printer_data_out)
		else $error("printer line not marking while idle");
	a_prn_rx_store: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		prn_rx_valid |=> prn_full_ff && prn_rxbuf_ff == $past(prn_rx_data))
		else $error("printer character not stored");
	a_status_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		rd_in && addr_in == spm_pkg::ADDR_STATUS |=> rdata_out[2:0] == $past({cd_on, dsr_on, cts_on}))
		else $error("status read wrong");
	a_sec_data_copy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$past(proto != spm_pkg::PROTO_ASYM) |-> sec_transmit_data_out == comm_transmit_data_out)
		else $error("secondary data differs outside asymmetric mode");
endmodule : spm_line_ctrl
`default_nettype wire

/* File: tb/spm_partner.sv */
`default_nettype none
// ********************************
// modem and printer far side
// ********************************
module spm_partner (
	input wire logic on_in,
	input wire logic prn_rdy_in,
	input wire logic clk_run_in,
	output logic [5:0] modem_out,
	output logic [3:0] idle_out,
	output logic prn_ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prx = 1'b1;
	logic lclk = 1'b1;
	// cts dsr cd ri si scts together, 0 = on, 1 = off
	assign modem_out = on_in ? 6'h00 : 6'h3F;
	// modem clock for both directions, 200 ns, rests high while not wanted
	initial forever #100 lclk = clk_run_in ? ~lclk : 1'b1;
	// printer data, receive clock, send clock, comm data; data rests at mark
	assign idle_out = {prx, lclk, lclk, 1'b1};
	// printer ready, high while it takes characters
	assign prn_ready_out = prn_rdy_in;
	// printer sends one 8N1 character, 16 bench clocks a bit
	task automatic send_byte(input logic [7:0] b);
		prx = 1'b0;
		#400;
		for (int i = 0; i < 8; i++) begin
			prx = b[i];
			#400;
		end
		prx = 1'b1;
		#400;
	endtask : send_byte
endmodule : spm_partner
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
// ********************************
// line control bench
// ********************************
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, reset_n_in, wr_in, rd_in, on, prdy, sel, run;
	logic [3:0] addr_in;
	logic [7:0] wdata_in, rdata_out;
	logic ctx, srq, sdat, ssr, trdy, spd, pdat, pcts, pdsr, prr;
	logic [5:0] mdm;
	logic [3:0] idl;
	int failures = 0;
	int checks = 0;
	wire ln = sel ? pdat : ctx;
	spm_partner far_u (.on_in(on), .prn_rdy_in(prdy), .clk_run_in(run), .modem_out(mdm), .idle_out(idl),
		.prn_ready_out(prr));
	spm_line_ctrl dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .comm_transmit_data_out(ctx),
		.comm_receive_data_in(idl[0]), .send_request_out(srq), .clear_to_send_in(mdm[0]),
		.data_set_ready_in(mdm[1]), .carrier_detect_in(mdm[2]), .speed_indicator_secondary_detect_in(mdm[4]),
		.sec_clear_to_send_in(mdm[5]), .sec_transmit_data_out(sdat), .send_clock_in(idl[1]),
		.modem_receive_clock_in(idl[2]), .secondary_send_request_out(ssr), .terminal_ready_out(trdy),
		.ring_indicator_in(mdm[3]), .modem_speed_select_out(spd), .printer_data_out(pdat),
		.printer_data_in(idl[3]), .printer_cts_out(pcts), .printer_dsr_out(pdsr), .printer_ready_in(prr));
	// clock, 25 ns period
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		chk("rdata", {1'b0, e}, {1'b0, rdata_out});
	endtask : rd
	// bounded wait for start bit, then sample each bit mid-cell, w clocks a bit
	task automatic frame(input logic p, input logic [7:0] e, input int w);
		logic [8:0] v;
		int n;
		sel = p;
		n = 0;
		while (ln === 1'b1 && n < 2000) begin
			@(negedge clk_in);
			n++;
		end
		repeat (w / 2) @(negedge clk_in);
		for (int i = 0; i < 9; i++) begin
			repeat (w) @(negedge clk_in);
			v[i] = ln;
		end
		chk("frame", {1'b1, e}, v);
	endtask : frame
	// control bits reach the modem lines, low meaning on
	task automatic test_control;
		wr(4'h0, 8'h1E);
		repeat (2) @(negedge clk_in);
		chk("modem outs", 9'h000, {5'h00, srq, trdy, ssr, spd});
		rd(4'h0, 8'h1E);
		rd(4'hF, 8'h00);
		$display("control test done");
	endtask : test_control
	// modem lines read back, then the secondary data bit in asymmetric mode
	task automatic test_status;
		@(posedge clk_in) on <= 1'b1;
		repeat (5) @(posedge clk_in);
		rd(4'h1, 8'h3F);
		wr(4'h9, 8'h00);
		wr(4'h0, 8'h40);
		repeat (2) @(negedge clk_in);
		chk("sec data", 9'h000, {8'h00, sdat});
		wr(4'h0, 8'h1E);
		@(posedge clk_in) on <= 1'b0;
		$display("status test done");
	endtask : test_status
	// one character on the internal rate, one on the modem send clock
	task automatic test_comm;
		wr(4'h5, 8'h00);
		wr(4'h6, 8'h00);
		// the lane takes a new divider only when its old count runs out
		repeat (300) @(posedge clk_in);
		wr(4'h3, 8'hA5);
		frame(1'b0, 8'hA5, 16);
		@(posedge clk_in) run <= 1'b1;
		wr(4'h0, 8'h01);
		wr(4'h3, 8'h5A);
		frame(1'b0, 8'h5A, 8);
		wr(4'h0, 8'h1E);
		@(posedge clk_in) run <= 1'b0;
		$display("comm test done");
	endtask : test_comm
	// pause on printer ready, printer input, then the variant that ignores ready
	task automatic test_printer;
		wr(4'h7, 8'h00);
		wr(4'h8, 8'h00);
		wr(4'h4, 8'h3C);
		sel = 1'b1;
		repeat (400) @(negedge clk_in) chk("paused line", 9'h001, {8'h00, ln});
		chk("paused", 9'h001, {8'h00, pdat});
		@(posedge clk_in) prdy <= 1'b1;
		frame(1'b1, 8'h3C, 16);
		far_u.send_byte(8'h13);
		repeat (4) @(posedge clk_in);
		rd(4'h4, 8'h13);
		@(posedge clk_in) prdy <= 1'b0;
		wr(4'h0, 8'h80);
		wr(4'h4, 8'h81);
		frame(1'b1, 8'h81, 16);
		$display("printer test done");
	endtask : test_printer
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	// watchdog, far beyond the expected run
	initial begin
		#500000;
		failures++;
		final_report;
	end
	// main sequence
	initial begin
		{reset_n_in, wr_in, rd_in, on, prdy, sel, run, addr_in, wdata_in} = '0;
		repeat (6) @(posedge clk_in);
		chk("reset lines", 9'h1FF, {ctx, srq, sdat, ssr, trdy, spd, pdat, pcts, pdsr});
		reset_n_in <= 1'b1;
		test_control;
		test_status;
		test_comm;
		test_printer;
		final_report;
	end
endmodule : testbench
`default_nettype wire
